/* pdh_defs.svh */
// Constants for the process data acknowledge handshake
//
// Contract
// - Sender increments transfer counter per new item
// - Receiver returns received counter in acknowledge field
// - Sender waits until acknowledge equals its counter; the controller skips the wait when the send force bit is set
// - Controller activates confirmed mode with control 0x03
// - Device echoes activated control value back
// - Device counts results, holds further results queued
// - Matching acknowledge releases next queued result
// - Controller counts outputs, awaits device acknowledge; launches at once when the send force bit is set
// - Changed output counter: adopt data, return counter
// - No adoption while output counter unchanged
// - Unacknowledged counter advance reports echo 0x83
// - Info-only mode: acknowledge not needed, ignored
`ifndef PDH_DEFS_SVH
`define PDH_DEFS_SVH

// Control byte values and flags
`define PDH_CTRL_INFO   8'h01
`define PDH_CTRL_CONF   8'h03
`define PDH_ECHO_ERR    8'h80
`define PDH_CNT_RST     8'h00

// Controller register offsets (byte addresses)
`define PDH_OFS_MODE    12'h000
`define PDH_OFS_TXDATA  12'h004
`define PDH_OFS_SEND    12'h008
`define PDH_OFS_STATUS  12'h00c
`define PDH_OFS_COUNT   12'h010
`define PDH_OFS_RXDATA  12'h014

// Send register fields
`define PDH_SEND_BIT    0
`define PDH_FORCE_BIT   1

`endif

/* pdh_pkg.sv */
// Types and shared decoding for the process data handshake
package pdh_pkg;

    `include "pdh_defs.svh"

    typedef enum logic [1:0] {
        mode_off,
        info_only_mode,
        confirmed_mode
    } pdh_mode_t;

    // Mode selected by a handshake control byte
    function automatic pdh_mode_t pdh_mode(input logic [7:0] c);
        if (c[0] && c[1]) begin
            return confirmed_mode;
        end else if (c[0]) begin
            return info_only_mode;
        end
        return mode_off;
    endfunction

    // Echo value for an activated control byte
    function automatic logic [7:0] pdh_echo(input logic [7:0] c);
        if (c[0]) begin
            return c & `PDH_CTRL_CONF;
        end
        return 8'h00;
    endfunction

endpackage

/* pdh_link_if.sv */
// Cyclic process data link between controller and device
`timescale 1ns/1ns
interface pdh_link_if #(
    parameter int DW = 32
);
    // Controller to device
    logic [DW-1:0] out_data;
    logic [7:0]    out_ctrl;
    logic [7:0]    out_cnt;
    logic [7:0]    in_ctrl;
    logic [7:0]    in_ack;
    // Device to controller
    logic [DW-1:0] in_data;
    logic [7:0]    in_cnt;
    logic [7:0]    in_echo;
    logic [7:0]    out_echo;
    logic [7:0]    out_ack;

    modport device (
        input  out_data, out_ctrl, out_cnt, in_ctrl, in_ack,
        output in_data, in_cnt, in_echo, out_echo, out_ack
    );
    modport plc (
        output out_data, out_ctrl, out_cnt, in_ctrl, in_ack,
        input  in_data, in_cnt, in_echo, out_echo, out_ack
    );
endinterface

/* pdh_device.sv */
// Device end: result queue, output adoption and acknowledge
`timescale 1ns/1ns
`include "pdh_defs.svh"
module pdh_device #(
    parameter int DW = 32
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    pdh_link_if.device         link,
    input  wire logic [DW-1:0] res_data,
    input  wire logic          res_valid,
    output logic               res_ready,
    output logic [DW-1:0]      cmd_data,
    output logic               cmd_valid,
    input  wire logic          cmd_ready,
    output logic               hs_error
);
    import pdh_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [DW-1:0]      in_data;
        logic [7:0]         in_cnt;
        logic [7:0]         in_echo;
        logic [7:0]         out_echo;
        logic [7:0]         out_ack;
        logic [7:0]         out_seen;
        logic [1:0][DW-1:0] fifo;
        logic               rd_ptr;
        logic               wr_ptr;
        logic [1:0]         fill;
        logic               res_ready;
        logic [DW-1:0]      cmd_data;
        logic [7:0]         cmd_cnt;
        logic               cmd_valid;
        logic               err;
    } pdh_dev_st_t;

    pdh_dev_st_t st_ff;
    pdh_dev_st_t nxt_st;
    pdh_mode_t   in_mode;
    pdh_mode_t   out_mode;
    logic        push;
    logic        pop;
    logic        acked;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Mode decode of both control bytes
    assign in_mode  = pdh_mode(link.in_ctrl);
    assign out_mode = pdh_mode(link.out_ctrl);

    // Result handshake terms
    assign push  = res_valid && st_ff.res_ready;
    assign acked = (in_mode == info_only_mode)
                || (link.in_ack == st_ff.in_cnt);
    assign pop   = (in_mode != mode_off) && (st_ff.fill != 2'd0) && acked;

    always_comb begin
        nxt_st = st_ff;

        // Activation echo, error flag on output direction
        nxt_st.in_echo  = pdh_echo(link.in_ctrl);
        nxt_st.out_echo = pdh_echo(link.out_ctrl)
                        | (st_ff.err ? `PDH_ECHO_ERR : 8'h00);

        // User takes adopted command; confirmed mode returns its count
        if (st_ff.cmd_valid && cmd_ready) begin
            nxt_st.cmd_valid = 1'b0;
            if (out_mode == confirmed_mode) begin
                nxt_st.out_ack = st_ff.cmd_cnt;
            end
        end

        // Output direction: adopt only on a counter change
        if (out_mode == mode_off) begin
            nxt_st.out_seen = link.out_cnt;
            nxt_st.err      = 1'b0;
        end else if (link.out_cnt != st_ff.out_seen) begin
            nxt_st.out_seen = link.out_cnt;
            if (out_mode == confirmed_mode && st_ff.cmd_valid) begin
                nxt_st.err = 1'b1;
            end else begin
                nxt_st.cmd_data  = link.out_data;
                nxt_st.cmd_cnt   = link.out_cnt;
                nxt_st.cmd_valid = 1'b1;
            end
        end

        // Input direction: send head of queue when released
        if (pop) begin
            nxt_st.in_data = st_ff.fifo[st_ff.rd_ptr];
            nxt_st.in_cnt  = st_ff.in_cnt + 8'h01;
            nxt_st.rd_ptr  = ~st_ff.rd_ptr;
        end

        // Queue write, held while unacknowledged
        if (push) begin
            nxt_st.fifo[st_ff.wr_ptr] = res_data;
            nxt_st.wr_ptr = ~st_ff.wr_ptr;
        end

        // Fill level and back-pressure
        nxt_st.fill = 2'(st_ff.fill + {1'b0, push} - {1'b0, pop});
        nxt_st.res_ready = (nxt_st.fill != 2'd2);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Link side
    assign link.in_data  = st_ff.in_data;
    assign link.in_cnt   = st_ff.in_cnt;
    assign link.in_echo  = st_ff.in_echo;
    assign link.out_echo = st_ff.out_echo;
    assign link.out_ack  = st_ff.out_ack;

    // User side
    assign res_ready = st_ff.res_ready;
    assign cmd_data  = st_ff.cmd_data;
    assign cmd_valid = st_ff.cmd_valid;
    assign hs_error  = st_ff.err;

endmodule

/* pdh_plc.sv */
// Controller end: APB register file driving the handshake link
`timescale 1ns/1ns
`include "pdh_defs.svh"
module pdh_plc #(
    parameter int DW = 32
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    pdh_link_if.plc          link
);
    import pdh_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0]    out_ctrl;
        logic [7:0]    in_ctrl;
        logic [DW-1:0] tx_stage;
        logic [DW-1:0] out_data;
        logic [7:0]    out_cnt;
        logic [7:0]    in_ack;
        logic          tx_pend;
        logic          tx_force;
        logic [DW-1:0] rx_data;
        logic [7:0]    in_seen;
        logic          rx_valid;
        logic [31:0]   prdata;
        logic          pready;
        logic          pslverr;
    } pdh_plc_st_t;

    pdh_plc_st_t st_ff;
    pdh_plc_st_t nxt_st;
    pdh_mode_t   in_mode;
    pdh_mode_t   out_mode;
    logic        done;
    logic        wr;
    logic        rd;

    // Known register offsets
    function automatic logic reg_hit(input logic [11:0] a);
        return a == `PDH_OFS_MODE || a == `PDH_OFS_TXDATA || a == `PDH_OFS_SEND
            || a == `PDH_OFS_STATUS || a == `PDH_OFS_COUNT || a == `PDH_OFS_RXDATA;
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Mode decode and bus phases
    assign in_mode  = pdh_mode(st_ff.in_ctrl);
    assign out_mode = pdh_mode(st_ff.out_ctrl);
    assign done     = psel && penable && st_ff.pready;
    assign wr       = done && pwrite && reg_hit(paddr);
    assign rd       = done && !pwrite && (paddr == `PDH_OFS_RXDATA);

    always_comb begin
        nxt_st = st_ff;

        // Access phase: answer one cycle after it opens
        nxt_st.pready  = psel && penable && !st_ff.pready;
        nxt_st.pslverr = nxt_st.pready && !reg_hit(paddr);
        nxt_st.prdata  = 32'h0;
        if (nxt_st.pready && !pwrite) begin
            unique case (paddr)
                `PDH_OFS_MODE:   nxt_st.prdata = {16'h0, st_ff.in_ctrl, st_ff.out_ctrl};
                `PDH_OFS_TXDATA: nxt_st.prdata = 32'(st_ff.tx_stage);
                `PDH_OFS_STATUS: nxt_st.prdata = {13'h0, link.out_echo[7], st_ff.rx_valid,
                                     st_ff.tx_pend, link.in_echo, link.out_echo};
                `PDH_OFS_COUNT:  nxt_st.prdata = {st_ff.in_ack, link.in_cnt,
                                     link.out_ack, st_ff.out_cnt};
                `PDH_OFS_RXDATA: nxt_st.prdata = 32'(st_ff.rx_data);
                default:         nxt_st.prdata = 32'h0;
            endcase
        end

        // Register writes at the completing edge
        if (wr) begin
            unique case (paddr)
                `PDH_OFS_MODE: begin
                    nxt_st.out_ctrl = pwdata[7:0];
                    nxt_st.in_ctrl  = pwdata[15:8];
                end
                `PDH_OFS_TXDATA: nxt_st.tx_stage = pwdata[DW-1:0];
                `PDH_OFS_SEND: begin
                    nxt_st.tx_pend  = st_ff.tx_pend | pwdata[`PDH_SEND_BIT];
                    nxt_st.tx_force = pwdata[`PDH_FORCE_BIT];
                end
                default: ;
            endcase
        end

        // Launch pending item once the previous one is acknowledged, or at once in info-only mode or when forced
        if (st_ff.tx_pend && out_mode != mode_off
            && (out_mode == info_only_mode || st_ff.tx_force
                || link.out_ack == st_ff.out_cnt)) begin
            nxt_st.out_data = st_ff.tx_stage;
            nxt_st.out_cnt  = st_ff.out_cnt + 8'h01;
            nxt_st.tx_pend  = 1'b0;
            nxt_st.tx_force = 1'b0;
        end

        // Reading received data acknowledges it in confirmed mode
        if (rd) begin
            nxt_st.rx_valid = 1'b0;
            if (in_mode == confirmed_mode) begin
                nxt_st.in_ack = st_ff.in_seen;
            end
        end

        // New result seen by counter change; set wins over read
        if (in_mode != mode_off && link.in_cnt != st_ff.in_seen) begin
            nxt_st.in_seen  = link.in_cnt;
            nxt_st.rx_data  = link.in_data;
            nxt_st.rx_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Single state register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Bus and link side
    assign prdata        = st_ff.prdata;
    assign pready        = st_ff.pready;
    assign pslverr       = st_ff.pslverr;
    assign link.out_data = st_ff.out_data;
    assign link.out_ctrl = st_ff.out_ctrl;
    assign link.out_cnt  = st_ff.out_cnt;
    assign link.in_ctrl  = st_ff.in_ctrl;
    assign link.in_ack   = st_ff.in_ack;

endmodule

/* pdh_assertions.sv */
// Concurrent checks on the handshake link between both ends
`timescale 1ns/1ns
module pdh_assertions (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic [7:0] out_ctrl,
    input wire logic [7:0] out_cnt,
    input wire logic [7:0] in_ctrl,
    input wire logic [7:0] in_ack,
    input wire logic [7:0] in_cnt,
    input wire logic [7:0] in_echo,
    input wire logic [7:0] out_echo,
    input wire logic [7:0] out_ack
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Echo bytes track their control byte one cycle late
    property p_out_echo;
        out_echo[6:0] == ($past(out_ctrl[0]) ? {5'h00, $past(out_ctrl[1:0])} : 7'h00);
    endproperty
    property p_in_echo;
        in_echo == ($past(in_ctrl[0]) ? {6'h00, $past(in_ctrl[1:0])} : 8'h00);
    endproperty
    // Error flag in confirmed mode gives the full error echo
    property p_err_echo;
        out_echo[7] && $past(out_ctrl) == 8'h03 |-> out_echo == 8'h83;
    endproperty
    // Acknowledge frozen behind the counter when the error appears
    property p_err_ack;
        $rose(out_echo[7]) |-> $stable(out_ack) && out_ack != out_cnt;
    endproperty
    // Acknowledges only ever return the received counter
    property p_out_ack;
        $changed(out_ack) |-> out_ack == out_cnt;
    endproperty
    property p_in_ack;
        $changed(in_ack) |-> in_ack == in_cnt;
    endproperty
    // Counters step by one and wrap
    property p_in_step;
        $changed(in_cnt) |-> in_cnt == $past(in_cnt) + 8'h01;
    endproperty
    property p_out_step;
        $changed(out_cnt) |-> out_cnt == $past(out_cnt) + 8'h01;
    endproperty
    // Confirmed results leave only after the previous one was acknowledged
    property p_in_wait;
        $changed(in_cnt) && $past(in_ctrl) == 8'h03 |-> $past(in_ack) == $past(in_cnt);
    endproperty

    a_out_echo: assert property (p_out_echo) else $error("output echo wrong");
    a_in_echo: assert property (p_in_echo) else $error("input echo wrong");
    a_err_echo: assert property (p_err_echo) else $error("error echo wrong");
    a_err_ack: assert property (p_err_ack) else $error("ack moved on error");
    a_out_ack: assert property (p_out_ack) else $error("output ack wrong");
    a_in_ack: assert property (p_in_ack) else $error("input ack wrong");
    a_in_step: assert property (p_in_step) else $error("input count step");
    a_out_step: assert property (p_out_step) else $error("output count step");
    a_in_wait: assert property (p_in_wait) else $error("sent before ack");

    // Main scenarios reached
    c_err: cover property ($rose(out_echo[7]));
    c_in_send: cover property ($changed(in_cnt) && in_ctrl == 8'h03);
    c_out_ack: cover property ($changed(out_ack));
endmodule

/* pdh_tb.sv */
// Self-checking testbench joining controller and device ends
`timescale 1ns/1ns
`include "pdh_defs.svh"
module pdh_tb;
    import pdh_pkg::*;
    logic        pclk;
    logic        presetn;
    logic [11:0] paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] res_data;
    logic        res_valid;
    logic        res_ready;
    logic [31:0] cmd_data;
    logic        cmd_valid;
    logic        cmd_ready;
    logic        hs_error;
    logic [31:0] rd;
    logic        rd_err;
    int          failures = 0;
    int          check_count = 0;
    int          cycles = 0;

    pdh_link_if #(.DW(32)) link ();
    pdh_plc u_pdh_plc (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link(link));
    pdh_device u_pdh_device (.pclk(pclk), .presetn(presetn), .link(link),
        .res_data(res_data), .res_valid(res_valid), .res_ready(res_ready),
        .cmd_data(cmd_data), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .hs_error(hs_error));
    pdh_assertions u_pdh_assertions (.pclk(pclk), .presetn(presetn),
        .out_ctrl(link.out_ctrl), .out_cnt(link.out_cnt), .in_ctrl(link.in_ctrl),
        .in_ack(link.in_ack), .in_cnt(link.in_cnt), .in_echo(link.in_echo),
        .out_echo(link.out_echo), .out_ack(link.out_ack));

    // ----------------------------------------
    // Clock, timeout and shared tasks
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    // Cuts a hang short
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd      = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Reads until the masked field matches, then compares
    task automatic poll(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            apb(1'b0, a, 32'h0);
            n++;
        end while ((rd & m) !== e && n < 30);
        chk(rd & m, e);
    endtask

    task automatic push(input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        res_data  <= d;
        res_valid <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (res_ready !== 1'b1 && n < 50);
        res_valid <= 1'b0;
    endtask

    task automatic wait_cmd();
        int n;
        n = 0;
        while (cmd_valid !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        poll(`PDH_OFS_COUNT, 32'hffffffff, 32'h0);
        poll(`PDH_OFS_STATUS, 32'hffffffff, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(rd_err), 32'h1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_out_conf();
        apb(1'b1, `PDH_OFS_MODE, 32'h0303);
        poll(`PDH_OFS_MODE, 32'hffffffff, 32'h0303);
        poll(`PDH_OFS_STATUS, 32'hffff, 32'h0303);
        for (int i = 1; i <= 2; i++) begin
            apb(1'b1, `PDH_OFS_TXDATA, 32'ha5a50000 + i);
            apb(1'b1, `PDH_OFS_SEND, 32'h1);
            wait_cmd();
            chk(cmd_data, 32'ha5a50000 + i);
            poll(`PDH_OFS_COUNT, 32'hffff, {16'h0, 8'(i), 8'(i)});
        end
        // New staging data without a send: nothing adopted
        apb(1'b1, `PDH_OFS_TXDATA, 32'h5a5a5a5a);
        poll(`PDH_OFS_TXDATA, 32'hffffffff, 32'h5a5a5a5a);
        chk(32'(cmd_valid), 32'h0);
        chk(cmd_data, 32'ha5a50002);
        poll(`PDH_OFS_COUNT, 32'hffff, 32'h0202);
        $display("test output confirmed done");
    endtask

    task automatic t_in_conf();
        for (int i = 0; i < 3; i++) begin
            push(32'hc0de0000 + i);
        end
        poll(`PDH_OFS_COUNT, 32'hffff0000, 32'h00010000);
        chk(32'(res_ready), 32'h0);
        for (int i = 0; i < 3; i++) begin
            poll(`PDH_OFS_COUNT, 32'hffff0000, {8'(i), 8'(i + 1), 16'h0});
            poll(`PDH_OFS_STATUS, 32'h20000, 32'h20000);
            apb(1'b0, `PDH_OFS_RXDATA, 32'h0);
            chk(rd, 32'hc0de0000 + i);
        end
        poll(`PDH_OFS_COUNT, 32'hffff0000, 32'h03030000);
        chk(32'(res_ready), 32'h1);
        $display("test input confirmed done");
    endtask

    task automatic t_info();
        apb(1'b1, `PDH_OFS_MODE, 32'h0101);
        poll(`PDH_OFS_STATUS, 32'hffff, 32'h0101);
        push(32'h11110000);
        // Enough results to wrap the input counter past 0xff
        for (int i = 1; i <= 257; i++) begin
            push(32'h11110000 + i);
        end
        poll(`PDH_OFS_COUNT, 32'hffff0000, 32'h03050000);
        apb(1'b0, `PDH_OFS_RXDATA, 32'h0);
        chk(rd, 32'h11110101);
        poll(`PDH_OFS_COUNT, 32'hff000000, 32'h03000000);
        apb(1'b1, `PDH_OFS_SEND, 32'h1);
        apb(1'b1, `PDH_OFS_SEND, 32'h1);
        poll(`PDH_OFS_COUNT, 32'hffff, 32'h0204);
        $display("test info mode done");
    endtask

    task automatic t_err();
        @(posedge pclk);
        cmd_ready <= 1'b0;
        apb(1'b1, `PDH_OFS_MODE, 32'h0303);
        apb(1'b1, `PDH_OFS_TXDATA, 32'hc0c0c0c0);
        apb(1'b1, `PDH_OFS_SEND, 32'h3);
        wait_cmd();
        chk(cmd_data, 32'hc0c0c0c0);
        apb(1'b1, `PDH_OFS_TXDATA, 32'hd0d0d0d0);
        apb(1'b1, `PDH_OFS_SEND, 32'h3);
        poll(`PDH_OFS_STATUS, 32'h400ff, 32'h40083);
        poll(`PDH_OFS_COUNT, 32'hffff, 32'h0206);
        chk(cmd_data, 32'hc0c0c0c0);
        chk(32'(hs_error), 32'h1);
        apb(1'b1, `PDH_OFS_MODE, 32'h0);
        poll(`PDH_OFS_STATUS, 32'h400ff, 32'h0);
        chk(32'(hs_error), 32'h0);
        cmd_ready <= 1'b1;
        $display("test handshake error done");
    endtask

    // Reset, then the scenarios in order
    initial begin
        presetn   = 1'b0;
        paddr     = 12'h000;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        pwdata    = 32'h0;
        res_data  = 32'h0;
        res_valid = 1'b0;
        cmd_ready = 1'b1;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_out_conf();
        t_in_conf();
        t_info();
        t_err();
        final_report();
    end
endmodule
